// ---- mic_insert_hook_detect.sv ----
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Purpose: mic insertion and hook-switch detect with sticky flags over APB
// Assumes: mic_present_raw and hook_pressed_raw are comparator outputs on pins
// Notes: status is cleared by reading it
module mic_insert_hook_detect (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire mic_hook_pkg::addr_t paddr,
   input wire mic_hook_pkg::word_t pwdata,
   output logic pready,
   output logic pslverr,
   output mic_hook_pkg::word_t prdata,
   input wire logic mic_present_raw,
   input wire logic hook_pressed_raw,
   output logic irq,
   output logic gpio_state
);
   import mic_hook_pkg::*;
`include "mic_hook_consts.svh"
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] sync2;
      logic [3:0] ctrl;
      logic [1:0] status;
      logic [1:0] mask;
      logic [7:0] mic_delay;
      logic [7:0] div_max;
      logic [7:0] div_cnt;
      logic stb;
      logic gpio;
      word_t rdata;
      logic err;
      logic acc_seen;
   } top_s;
   top_s q, d;
   debounce_if mic_if();
   debounce_if hook_if();
   level_debounce u_mic (.pclk(pclk), .presetn(presetn), .dif(mic_if.filter));
   level_debounce u_hook (.pclk(pclk), .presetn(presetn), .dif(hook_if.filter));
   assign mic_if.sample_stb = q.stb;
   assign mic_if.raw_level = q.sync2[0];
   assign mic_if.need_count = q.mic_delay;
   assign hook_if.sample_stb = q.stb;
   assign hook_if.raw_level = q.sync2[1];
   assign hook_if.need_count = `HOOK_SAMPLES;
   logic apb_acc, apb_cap, apb_done, mic_ev, hook_ev;
   always_comb begin
      apb_acc = psel && penable;
      // first access cycle captures read data and error, the second is the pready edge
      apb_cap = apb_acc && !q.acc_seen;
      apb_done = apb_acc && q.acc_seen;
      // polarity 0 catches presence, 1 catches absence
      mic_ev = mic_if.changed && (mic_if.steady != q.ctrl[`CTRL_MIC_POL]);
      hook_ev = hook_if.changed && (hook_if.steady != q.ctrl[`CTRL_HOOK_POL]);
   end
   always_comb begin
      d = q;
      d.sync1 = {hook_pressed_raw, mic_present_raw};
      d.sync2 = q.sync1;
      d.stb = 1'b0;
      if (q.div_cnt >= q.div_max) begin
         d.div_cnt = `ZERO8;
         d.stb = 1'b1;
      end else begin
         d.div_cnt = q.div_cnt + `CNT_ONE;
      end
      d.acc_seen = apb_cap;
      d.rdata = '0;
      d.err = 1'b0;
      if (apb_cap && pwrite) begin
         case (paddr)
            `ADDR_CTRL, `ADDR_MASK, `ADDR_DELAY, `ADDR_STATUS, `ADDR_STATE: d.err = 1'b0;
            default: d.err = 1'b1;
         endcase
      end
      if (apb_cap && !pwrite) begin
         case (paddr)
            `ADDR_CTRL: d.rdata = {28'h0000000, q.ctrl};
            `ADDR_STATUS: d.rdata = {30'h00000000, q.status};
            `ADDR_MASK: d.rdata = {30'h00000000, q.mask};
            `ADDR_STATE: d.rdata = {30'h00000000, hook_if.steady, mic_if.steady};
            `ADDR_DELAY: d.rdata = {16'h0000, q.div_max, q.mic_delay};
            default: d.err = 1'b1;
         endcase
      end
      // writes land on the pready edge only
      if (apb_done && pwrite) begin
         case (paddr)
            `ADDR_CTRL: d.ctrl = pwdata[3:0];
            `ADDR_MASK: d.mask = pwdata[1:0];
            `ADDR_DELAY: begin
               d.mic_delay = (pwdata[7:0] == `ZERO8) ? `CNT_ONE : pwdata[7:0];
               d.div_max = pwdata[15:8];
            end
            default: ;
         endcase
      end
      // the read clears only the flags it reported, so a flag set after capture survives
      if (apb_done && !pwrite && paddr == `ADDR_STATUS) begin
         d.status = q.status & ~q.rdata[`FLAG_HOOK:`FLAG_MIC];
      end
      // a new event wins over the read-clear in the same cycle
      if (mic_ev) begin
         d.status[`FLAG_MIC] = 1'b1;
      end
      if (hook_ev) begin
         d.status[`FLAG_HOOK] = 1'b1;
      end
      d.gpio = q.ctrl[`CTRL_PIN_EN] &&
               (q.ctrl[`CTRL_PIN_SEL] ? hook_if.steady : mic_if.steady);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.mic_delay <= `MIC_DELAY_RESET;
         q.div_max <= `SAMPLE_DIV_RESET;
      end else begin
         q <= d;
      end
   end
   // one wait state: data and error are registered at the first access cycle
   assign pready = apb_done;
   assign prdata = q.rdata;
   assign pslverr = pready && q.err;
   assign irq = |(q.status & q.mask);
   assign gpio_state = q.gpio;

   a_hook_count: assert property (@(posedge pclk) disable iff (!presetn)
      hook_if.changed |-> $past(hook_if.raw_level) == hook_if.steady)
      else $error("hook state changed against the sampled level");
   a_hook_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !hook_if.changed |-> hook_if.steady == $past(hook_if.steady))
      else $error("hook state moved without a change pulse");
   a_mic_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !mic_if.changed |-> mic_if.steady == $past(mic_if.steady))
      else $error("mic state moved without a change pulse");
   a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      mic_ev |=> q.status[`FLAG_MIC])
      else $error("mic event did not set its flag");
   a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
      q.status[`FLAG_HOOK] && !(apb_done && !pwrite && paddr == `ADDR_STATUS) |=> q.status[`FLAG_HOOK])
      else $error("hook flag dropped without a status read");
   a_polarity_sel: assert property (@(posedge pclk) disable iff (!presetn)
      hook_if.changed && hook_if.steady && !q.ctrl[`CTRL_HOOK_POL] |=> q.status[`FLAG_HOOK])
      else $error("press with polarity 0 raised no flag");
   a_gpio_mirror: assert property (@(posedge pclk) disable iff (!presetn)
      q.ctrl[`CTRL_PIN_EN] && !q.ctrl[`CTRL_PIN_SEL] && $stable(q.ctrl) |=> gpio_state == $past(mic_if.steady))
      else $error("pin does not mirror steady mic state");
   a_rel_count: assert property (@(posedge pclk) disable iff (!presetn)
      hook_if.changed && !hook_if.steady |-> $past(hook_if.raw_level) == 1'b0)
      else $error("release without low samples");
endmodule
`default_nettype wire

// ---- mic_hook_consts.svh ----
// Purpose: constants for the microphone insert and hook-switch detector
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register offsets are byte addresses
`ifndef MIC_HOOK_CONSTS_SVH
`define MIC_HOOK_CONSTS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_STATE 12'h00C
`define ADDR_DELAY 12'h010
`define CTRL_MIC_POL 0
`define CTRL_HOOK_POL 1
`define CTRL_PIN_SEL 2
`define CTRL_PIN_EN 3
`define FLAG_MIC 0
`define FLAG_HOOK 1
`define HOOK_SAMPLES 8'd10
`define MIC_DELAY_RESET 8'h20
`define SAMPLE_DIV_RESET 8'h04
`define CNT_ONE 8'h01
`define ZERO8 8'h00
`endif

// ---- debounce_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// Purpose: carries one debouncer's controls and outputs
// Assumes: single pclk domain
// Notes: none
interface debounce_if;
   logic sample_stb;
   logic raw_level;
   logic [7:0] need_count;
   logic steady;
   logic changed;
   modport owner (output sample_stb, output raw_level, output need_count, input steady, input changed);
   modport filter (input sample_stb, input raw_level, input need_count, output steady, output changed);
endinterface
`default_nettype wire

// ---- level_debounce.sv ----
`timescale 1ns/1ns
`default_nettype none
// Purpose: successive-sample debouncer for one comparator level
// Assumes: level already synchronised
// Notes: changed pulses one cycle when steady flips
module level_debounce (
   input wire logic pclk,
   input wire logic presetn,
   debounce_if.filter dif
);
`include "mic_hook_consts.svh"
   typedef struct packed {
      logic steady;
      logic changed;
      logic [7:0] count;
   } deb_s;
   deb_s q, d;
   always_comb begin
      d = q;
      d.changed = 1'b0;
      if (dif.sample_stb) begin
         if (dif.raw_level == q.steady) begin
            d.count = `ZERO8;
         end else if (q.count + `CNT_ONE >= dif.need_count) begin
            d.steady = dif.raw_level;
            d.changed = 1'b1;
            d.count = `ZERO8;
         end else begin
            d.count = q.count + `CNT_ONE;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign dif.steady = q.steady;
   assign dif.changed = q.changed;
endmodule
`default_nettype wire

// ---- mic_hook_pkg.sv ----
// Purpose: types for the microphone insert and hook-switch detector
// Assumes: constants come from mic_hook_consts.svh
// Notes: none
package mic_hook_pkg;
   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;
endpackage

// ---- jack_model.sv ----
// Purpose: headset jack with microphone and hook switch
// Assumes: levels change only just after a pclk edge
// Notes: chatter flips the level every cycle so no run of samples can qualify
`timescale 1ns/1ns
`default_nettype none
module jack_model (
   input wire logic pclk,
   input wire logic want_mic,
   input wire logic want_hook,
   input wire logic mic_chatter,
   input wire logic hook_chatter,
   output logic mic_present_raw,
   output logic hook_pressed_raw
);
   logic flip_q = 1'b0;
   always @(posedge pclk) flip_q <= ~flip_q;
   assign mic_present_raw = want_mic ^ (mic_chatter & flip_q);
   assign hook_pressed_raw = want_hook ^ (hook_chatter & flip_q);
endmodule
`default_nettype wire

// ---- mic_insert_hook_detect_tb_top.sv ----
// Purpose: self-checking bench for the mic insert and hook detector
// Assumes: divider 0 so the pins are sampled every pclk
// Notes: host sequence runs insert, press, release, removal
`timescale 1ns/1ns
`default_nettype none
`include "mic_hook_consts.svh"
module mic_insert_hook_detect_tb_top;
   import mic_hook_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   addr_t paddr = 12'h000;
   word_t pwdata = 32'h0;
   logic wm = 1'b0;
   logic wh = 1'b0;
   logic cm = 1'b0;
   logic ch = 1'b0;
   logic pready, pslverr, irq, gpio_state, mic_raw, hook_raw, err;
   word_t prdata, rd;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;
   mic_insert_hook_detect i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .mic_present_raw(mic_raw), .hook_pressed_raw(hook_raw), .irq, .gpio_state);
   jack_model i_jack (.pclk, .want_mic(wm), .want_hook(wh), .mic_chatter(cm), .hook_chatter(ch),
      .mic_present_raw(mic_raw), .hook_pressed_raw(hook_raw));
   initial begin
      forever #2 pclk = ~pclk;
   end
   task automatic close_out();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic chk(input word_t got, input word_t exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input addr_t a, input word_t wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input addr_t a, input word_t exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // wait for the level interrupt, set the polarity, then poll status; a second poll must find it cleared
   task automatic expect_event(input word_t exp, input word_t ctrl);
      for (int i = 0; i < 80 && irq !== 1'b1; i++) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, `ADDR_CTRL, ctrl);
      rd_chk(`ADDR_STATUS, exp);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`ADDR_STATUS, 32'h0);
   endtask
   task automatic t_reset();
      rd_chk(`ADDR_CTRL, 32'h0);
      rd_chk(`ADDR_MASK, 32'h0);
      rd_chk(`ADDR_DELAY, {16'h0, `SAMPLE_DIV_RESET, `MIC_DELAY_RESET});
      apb(1'b1, `ADDR_DELAY, 32'h200);
      rd_chk(`ADDR_DELAY, 32'h201);
      apb(1'b0, 12'h014, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic t_insert();
      apb(1'b1, `ADDR_DELAY, 32'h3);
      apb(1'b1, `ADDR_MASK, 32'h3);
      apb(1'b1, `ADDR_CTRL, 32'h0);
      cm <= 1'b1;
      wm <= 1'b1;
      repeat (20) @(posedge pclk);
      rd_chk(`ADDR_STATUS, 32'h0);
      cm <= 1'b0;
      expect_event(32'h1, 32'h1);
      rd_chk(`ADDR_STATE, 32'h1);
      apb(1'b1, `ADDR_CTRL, 32'h9);
      repeat (2) @(posedge pclk);
      chk({31'h0, gpio_state}, 32'h1);
   endtask
   task automatic t_press();
      apb(1'b1, `ADDR_CTRL, 32'hD);
      wh <= 1'b1;
      repeat (9) @(posedge pclk);
      wh <= 1'b0;
      repeat (8) @(posedge pclk);
      rd_chk(`ADDR_STATUS, 32'h0);
      wh <= 1'b1;
      ch <= 1'b1;
      repeat (30) @(posedge pclk);
      rd_chk(`ADDR_STATUS, 32'h0);
      ch <= 1'b0;
      expect_event(32'h2, 32'hF);
      chk({31'h0, gpio_state}, 32'h1);
   endtask
   task automatic t_release();
      apb(1'b1, `ADDR_MASK, 32'h1);
      wh <= 1'b0;
      repeat (9) @(posedge pclk);
      wh <= 1'b1;
      repeat (8) @(posedge pclk);
      chk({31'h0, gpio_state}, 32'h1);
      rd_chk(`ADDR_STATUS, 32'h0);
      wh <= 1'b0;
      repeat (30) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, gpio_state}, 32'h0);
      apb(1'b1, `ADDR_CTRL, 32'hD);
      rd_chk(`ADDR_STATUS, 32'h2);
      apb(1'b1, `ADDR_MASK, 32'h3);
   endtask
   task automatic t_remove();
      wm <= 1'b0;
      expect_event(32'h1, 32'h0);
      rd_chk(`ADDR_STATE, 32'h0);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_insert();
      t_press();
      t_release();
      t_remove();
      close_out();
   end
endmodule
`default_nettype wire
